// file: rtl/queue_mem.sv
// First-in first-out message store with registered read data
`timescale 1ns/10ps
`default_nettype none
module queue_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic         flush,
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  input  wire logic         pop,
  output logic      [W-1:0] rd_data,
  output logic              empty,
  output logic              full
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic [AW:0]   count_next;
  logic          do_push;
  logic          do_pop;
  logic [AW-1:0] wr_ptr_inc;
  logic [AW-1:0] rd_ptr_inc;

  // ------------------------------------------------------------
  // Pointer and count control
  // ------------------------------------------------------------
  assign do_push    = push && !full;
  assign do_pop     = pop && !empty;
  assign wr_ptr_inc = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
  assign rd_ptr_inc = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
  assign count_next = flush ? '0 :
                      (do_push && !do_pop) ? count_reg + 1'b1 :
                      (do_pop && !do_push) ? count_reg - 1'b1 : count_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      empty      <= 1'b1;
      full       <= 1'b0;
      rd_data    <= '0;
    end else if (clk_en) begin
      wr_ptr_reg <= flush ? '0 : (do_push ? wr_ptr_inc : wr_ptr_reg);
      rd_ptr_reg <= flush ? '0 : (do_pop ? rd_ptr_inc : rd_ptr_reg);
      count_reg  <= count_next;
      empty      <= (count_next == '0);
      full       <= (count_next == (AW+1)'(DEPTH));
      if (do_pop) begin
        rd_data <= mem[rd_ptr_reg];
      end
    end
  end

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (clk_en && do_push && !flush) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end
endmodule : queue_mem
`default_nettype wire

// file: rtl/srq_pkg.sv
// Constants and types shared by the status byte and service request logic
//
// Behaviour
// - A query's response message is pushed into the output queue.
// - message_waiting_flag is set while the output queue holds data.
// - Reading an output message removes it from the output queue.
// - Each error or status event arriving while not full appends to a ten-entry FIFO error queue.
// - error_waiting_flag follows a non-empty error queue; reads remove entries.
// - Service request uses an 8-bit status byte and 8-bit enable mask.
// - Summary bits B0,B2,B3,B4,B5,B7 follow their sources without latching.
// - Status byte query returns master summary in B6, changes nothing.
// - Serial poll returns request flag in B6, then resets it.
// - Serial poll leaves master summary; it drops only when summaries clear.
// - Power-up clears all status byte bits; clear command empties the error queue and request flag, not the output queue.
// - Summary bits ANDed with enable bits, ORed together into B6.
// - Mask write loads the enable mask, readable back, zero on reset.
// - Enabled summary rising 0 to 1 sets request flag and asserts SRQ.
// - After a poll the same source may raise a fresh request.
// - Event register ANDed with its enable, ORed into one summary.
package srq_pkg;

  // ------------------------------------------------------------
  // Widths and depths
  // ------------------------------------------------------------
  localparam int BYTE_W   = 8;
  localparam int OQ_W     = 8;
  localparam int OQ_DEPTH = 16;
  localparam int OQ_AW    = 4;
  localparam int EQ_W     = 16;
  localparam int EQ_DEPTH = 10;
  localparam int EQ_AW    = 4;

  // ------------------------------------------------------------
  // Status byte bit positions
  // ------------------------------------------------------------
  localparam int BIT_MEAS  = 0;
  localparam int BIT_ERR   = 2;
  localparam int BIT_QUEST = 3;
  localparam int BIT_MSG   = 4;
  localparam int BIT_STD   = 5;
  localparam int BIT_SVC   = 6;
  localparam int BIT_OPER  = 7;

  // ------------------------------------------------------------
  // Reset values and fixed codes
  // ------------------------------------------------------------
  localparam logic [BYTE_W-1:0] MASK_RST     = 8'h00;
  localparam logic [BYTE_W-1:0] SBYTE_RST    = 8'h00;
  localparam logic [BYTE_W-1:0] MASK_WR_KEEP = 8'hBF;
  localparam logic [EQ_W-1:0]   NO_ERR_CODE  = 16'h0000;

  // ------------------------------------------------------------
  // Service request state
  // ------------------------------------------------------------
  typedef enum logic {SVC_IDLE, SVC_REQUEST} svc_state_t;

endpackage : srq_pkg

// file: rtl/status_byte_service_request.sv
// Output queue, error queue, status byte and service request logic
`timescale 1ns/10ps
`default_nettype none
module status_byte_service_request (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic                        resp_push,
  input  wire logic [srq_pkg::OQ_W-1:0]    resp_data,
  input  wire logic                        talk_read,
  input  wire logic                        err_push,
  input  wire logic [srq_pkg::EQ_W-1:0]    err_code,
  input  wire logic                        err_read,
  input  wire logic [srq_pkg::BYTE_W-1:0]  meas_event,
  input  wire logic [srq_pkg::BYTE_W-1:0]  meas_enable,
  input  wire logic [srq_pkg::BYTE_W-1:0]  quest_event,
  input  wire logic [srq_pkg::BYTE_W-1:0]  quest_enable,
  input  wire logic [srq_pkg::BYTE_W-1:0]  std_event,
  input  wire logic [srq_pkg::BYTE_W-1:0]  std_enable,
  input  wire logic [srq_pkg::BYTE_W-1:0]  oper_event,
  input  wire logic [srq_pkg::BYTE_W-1:0]  oper_enable,
  input  wire logic                        clear_cmd,
  input  wire logic                        mask_write,
  input  wire logic [srq_pkg::BYTE_W-1:0]  mask_data,
  input  wire logic                        sbyte_query,
  input  wire logic                        serial_poll,
  output logic                             resp_ready,
  output logic      [srq_pkg::OQ_W-1:0]    talk_data,
  output logic                             talk_valid,
  output logic      [srq_pkg::EQ_W-1:0]    err_data,
  output logic                             err_valid,
  output logic                             err_full,
  output logic      [srq_pkg::BYTE_W-1:0]  status_summary_byte,
  output logic      [srq_pkg::BYTE_W-1:0]  service_request_mask,
  output logic      [srq_pkg::BYTE_W-1:0]  sbyte_data,
  output logic                             sbyte_valid,
  output logic      [srq_pkg::BYTE_W-1:0]  poll_data,
  output logic                             poll_valid,
  output logic                             srq_o,
  output logic                             srq_oe
);
  import srq_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic              oq_empty;
  logic              oq_full;
  logic              eq_empty;
  logic              eq_full;
  logic [EQ_W-1:0]   eq_rd_data;
  logic              message_waiting_flag;
  logic              error_waiting_flag;
  logic              meas_sum;
  logic              quest_sum;
  logic              std_event_summary_flag;
  logic              oper_sum;
  logic [BYTE_W-1:0] summary_vec;
  logic [BYTE_W-1:0] enabled_vec;
  logic [BYTE_W-1:0] enabled_prev_reg;
  logic              master_summary_flag;
  logic              rise_any;
  logic              request_service_flag;
  svc_state_t        svc_state_reg;
  svc_state_t        svc_state_next;
  logic [BYTE_W-1:0] sbyte_next;
  logic [BYTE_W-1:0] poll_next;
  logic [BYTE_W-1:0] mask_next;
  logic              oq_pop;
  logic              eq_pop;
  logic              err_read_q_reg;
  logic              err_read_d_reg;
  logic [EQ_W-1:0]   err_word;

  // ------------------------------------------------------------
  // Output queue
  // ------------------------------------------------------------
  assign oq_pop = talk_read && !oq_empty;

  queue_mem #(
    .W     (OQ_W),
    .DEPTH (OQ_DEPTH),
    .AW    (OQ_AW)
  ) u_out_queue (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .flush     (1'b0),
    .push      (resp_push),
    .push_data (resp_data),
    .pop       (oq_pop),
    .rd_data   (talk_data),
    .empty     (oq_empty),
    .full      (oq_full)
  );

  // ------------------------------------------------------------
  // Error queue
  // ------------------------------------------------------------
  assign eq_pop = err_read && !eq_empty;

  queue_mem #(
    .W     (EQ_W),
    .DEPTH (EQ_DEPTH),
    .AW    (EQ_AW)
  ) u_err_queue (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .flush     (clear_cmd),
    .push      (err_push),
    .push_data (err_code),
    .pop       (eq_pop),
    .rd_data   (eq_rd_data),
    .empty     (eq_empty),
    .full      (eq_full)
  );

  assign err_word = err_read_q_reg ? eq_rd_data : NO_ERR_CODE;

  // ------------------------------------------------------------
  // Summary messages
  // ------------------------------------------------------------
  summary_gate #(.W(BYTE_W)) u_meas_gate (
    .event_bits  (meas_event),
    .enable_bits (meas_enable),
    .summary     (meas_sum)
  );

  summary_gate #(.W(BYTE_W)) u_quest_gate (
    .event_bits  (quest_event),
    .enable_bits (quest_enable),
    .summary     (quest_sum)
  );

  summary_gate #(.W(BYTE_W)) u_std_gate (
    .event_bits  (std_event),
    .enable_bits (std_enable),
    .summary     (std_event_summary_flag)
  );

  summary_gate #(.W(BYTE_W)) u_oper_gate (
    .event_bits  (oper_event),
    .enable_bits (oper_enable),
    .summary     (oper_sum)
  );

  assign message_waiting_flag = !oq_empty;
  assign error_waiting_flag   = !eq_empty;

  // Live summary levels, bit 6 and bit 1 always zero
  assign summary_vec = {oper_sum, 1'b0, std_event_summary_flag,
                        message_waiting_flag, quest_sum,
                        error_waiting_flag, 1'b0, meas_sum};

  // ------------------------------------------------------------
  // Master summary and service request
  // ------------------------------------------------------------
  assign enabled_vec         = summary_vec & service_request_mask;
  assign master_summary_flag = |enabled_vec;
  assign rise_any            = |(enabled_vec & ~enabled_prev_reg);
  assign request_service_flag = (svc_state_reg == SVC_REQUEST);

  always_comb begin
    svc_state_next = svc_state_reg;
    case (svc_state_reg)
      SVC_IDLE: begin
        if (rise_any) begin
          svc_state_next = SVC_REQUEST;
        end
      end
      SVC_REQUEST: begin
        if ((serial_poll || clear_cmd) && !rise_any) begin
          svc_state_next = SVC_IDLE;
        end
      end
      default: begin
        svc_state_next = SVC_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Read-back values and mask update
  // ------------------------------------------------------------
  assign sbyte_next = {summary_vec[BYTE_W-1], master_summary_flag,
                       summary_vec[BIT_SVC-1:0]};
  assign poll_next  = {status_summary_byte[BYTE_W-1],
                       request_service_flag,
                       status_summary_byte[BIT_SVC-1:0]};
  assign mask_next  = mask_write ? (mask_data & MASK_WR_KEEP)
                                 : service_request_mask;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      svc_state_reg        <= SVC_IDLE;
      enabled_prev_reg     <= '0;
      service_request_mask <= MASK_RST;
      status_summary_byte  <= SBYTE_RST;
      srq_oe               <= 1'b0;
    end else if (clk_en) begin
      svc_state_reg        <= svc_state_next;
      enabled_prev_reg     <= enabled_vec;
      service_request_mask <= mask_next;
      status_summary_byte  <= sbyte_next;
      srq_oe               <= (svc_state_next == SVC_REQUEST);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sbyte_data     <= SBYTE_RST;
      sbyte_valid    <= 1'b0;
      poll_data      <= SBYTE_RST;
      poll_valid     <= 1'b0;
      talk_valid     <= 1'b0;
      err_valid      <= 1'b0;
      err_data       <= NO_ERR_CODE;
      err_read_q_reg <= 1'b0;
      err_read_d_reg <= 1'b0;
      resp_ready     <= 1'b0;
      err_full       <= 1'b0;
      srq_o          <= 1'b0;
    end else if (clk_en) begin
      sbyte_data     <= sbyte_query ? sbyte_next : sbyte_data;
      sbyte_valid    <= sbyte_query;
      poll_data      <= serial_poll ? poll_next : poll_data;
      poll_valid     <= serial_poll;
      talk_valid     <= oq_pop;
      err_read_d_reg <= err_read;
      err_valid      <= err_read_d_reg;
      err_data       <= err_read_d_reg ? err_word : err_data;
      err_read_q_reg <= eq_pop;
      resp_ready     <= !oq_full;
      err_full       <= eq_full;
      srq_o          <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_enabled_rise;
    clk_en && rise_any;
  endsequence

  sequence s_flag_raised;
    request_service_flag && srq_oe;
  endsequence

  property p_rise_requests;
    s_enabled_rise |=> s_flag_raised;
  endproperty

  a_rise_sets_request: assert property (p_rise_requests)
    else $error("Enabled summary rise did not raise service request");

  a_poll_clears_req: assert property (
    clk_en && serial_poll && !rise_any && !clear_cmd
    |=> !request_service_flag && poll_valid)
    else $error("Serial poll did not reset request flag");

  a_poll_reports_req: assert property (
    clk_en && serial_poll |=> poll_data[BIT_SVC] == $past(request_service_flag))
    else $error("Serial poll bit 6 differs from request flag");

  a_poll_keeps_mss: assert property (
    clk_en && serial_poll && master_summary_flag
    |=> status_summary_byte[BIT_SVC])
    else $error("Serial poll cleared master summary");

  a_query_reports_mss: assert property (
    clk_en && sbyte_query |=> sbyte_valid
    && sbyte_data[BIT_SVC] == $past(master_summary_flag)
    && sbyte_data[BIT_MSG] == $past(message_waiting_flag))
    else $error("Status byte query returned wrong bit 6");

  a_query_no_clear: assert property (
    clk_en && sbyte_query && request_service_flag && !serial_poll
    && !clear_cmd |=> request_service_flag)
    else $error("Status byte query changed the request flag");

  a_srq_follows_flag: assert property (
    srq_oe == request_service_flag)
    else $error("SRQ drive not equal to request flag");

  a_mask_gates_b6: assert property (
    clk_en |=> status_summary_byte[BIT_SVC]
    == |($past(summary_vec) & $past(service_request_mask)))
    else $error("Bit 6 is not the OR of enabled summaries");

  a_sbyte_live_bits: assert property (
    clk_en |=> status_summary_byte[BIT_ERR] == $past(error_waiting_flag)
    && status_summary_byte[BIT_STD] == $past(std_event_summary_flag))
    else $error("Summary bit latched instead of following source");

  a_mask_load: assert property (
    clk_en && mask_write |=> service_request_mask
    == ($past(mask_data) & MASK_WR_KEEP))
    else $error("Mask write not loaded");

  sequence s_clear_done;
    eq_empty && !request_service_flag;
  endsequence

  a_clear_empties: assert property (
    clk_en && clear_cmd && !rise_any |=> s_clear_done)
    else $error("Clear left error queue or request flag set");

  a_err_queue_cap: assert property (
    clk_en && eq_full && err_push && !eq_pop && !clear_cmd |=> eq_full)
    else $error("Error queue exceeded its ten entries");

  a_talk_removes: assert property (
    clk_en && talk_read && !oq_empty |=> talk_valid)
    else $error("Output queue read produced no data");

  a_msg_flag_push: assert property (
    clk_en && resp_push && !oq_full |=> !oq_empty ##1
    (!clk_en || status_summary_byte[BIT_MSG] || oq_empty))
    else $error("Message waiting flag not set after push");
endmodule : status_byte_service_request
`default_nettype wire

// file: rtl/summary_gate.sv
// Event register masked by its enable register into one summary level
`timescale 1ns/10ps
`default_nettype none
module summary_gate #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] event_bits,
  input  wire logic [W-1:0] enable_bits,
  output logic              summary
);
  logic [W-1:0] masked;

  // ------------------------------------------------------------
  // Per-bit AND, then OR
  // ------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_and
    assign masked[i] = event_bits[i] & enable_bits[i];
  end
  assign summary = |masked;
endmodule : summary_gate
`default_nettype wire

// file: testbench/gpib_ctrl_model.sv
// Bus controller model issuing queries, reads, polls and clears
`timescale 1ns/10ps
`default_nettype none
module gpib_ctrl_model (
  input  wire logic       clk_sys,
  output logic            resp_push,
  output logic [7:0]      resp_data,
  output logic            talk_read,
  output logic            err_read,
  output logic            clear_cmd,
  output logic            mask_write,
  output logic [7:0]      mask_data,
  output logic            sbyte_query,
  output logic            serial_poll
);
  logic [6:0] cmd = 7'h00;
  logic [7:0] dat = 8'h00;

  assign {serial_poll, sbyte_query, mask_write, clear_cmd, err_read,
          talk_read, resp_push} = cmd;
  assign resp_data = dat;
  assign mask_data = dat;

  // ----------------------------------------------------------
  // Command pulses
  // ----------------------------------------------------------
  // One pulse; data is inverted once released
  task automatic issue(input int k, input logic [7:0] d);
    @(posedge clk_sys);
    cmd <= 7'(7'h01 << k);
    dat <= d;
    @(posedge clk_sys);
    cmd <= 7'h00;
    dat <= ~d;
  endtask : issue

  // Query first, then address to talk
  task automatic query_talk(input logic [7:0] d);
    issue(0, d);
    issue(1, 8'h00);
  endtask : query_talk

  // Error query as a single err_read pulse, no talk addressing
  task automatic err_fetch();
    issue(2, 8'h00);
  endtask : err_fetch
endmodule : gpib_ctrl_model
`default_nettype wire

// file: testbench/status_byte_service_request_tb.sv
// Self-checking bench for the status byte and service request block
`timescale 1ns/10ps
`default_nettype none
module status_byte_service_request_tb;
  import srq_pkg::*;
  localparam int QRY = 0;
  localparam int TLK = 1;
  localparam int CLR = 3;
  localparam int MSK = 4;
  localparam int SBQ = 5;
  localparam int PLL = 6;

  logic              clk_sys;
  logic              sys_rst;
  logic              clk_en;
  logic              err_push;
  logic [EQ_W-1:0]   err_code;
  logic [BYTE_W-1:0] ev [4];
  logic [BYTE_W-1:0] en [4];
  int                err_total = 0;
  int                cmp_count = 0;
  wire logic         resp_push, talk_read, err_read, clear_cmd;
  wire logic         mask_write, sbyte_query, serial_poll;
  wire logic [7:0]   resp_data, mask_data, talk_data, sbyte_data, poll_data;
  wire logic [7:0]   status_summary_byte, service_request_mask;
  wire logic [15:0]  err_data;
  wire logic         talk_valid, err_valid, sbyte_valid, poll_valid;
  wire logic         resp_ready, err_full, srq_o, srq_oe;
  wire logic [3:0]   vld = {poll_valid, sbyte_valid, err_valid, talk_valid};

  status_byte_service_request i_status_byte_service_request (
    .clk_sys, .sys_rst, .clk_en, .resp_push, .resp_data, .talk_read,
    .err_push, .err_code, .err_read, .meas_event(ev[0]),
    .meas_enable(en[0]), .quest_event(ev[1]), .quest_enable(en[1]),
    .std_event(ev[2]), .std_enable(en[2]), .oper_event(ev[3]),
    .oper_enable(en[3]), .clear_cmd, .mask_write, .mask_data, .sbyte_query,
    .serial_poll, .resp_ready, .talk_data, .talk_valid, .err_data,
    .err_valid, .err_full, .status_summary_byte, .service_request_mask,
    .sbyte_data, .sbyte_valid, .poll_data, .poll_valid, .srq_o, .srq_oe
  );

  gpib_ctrl_model i_gpib_ctrl_model (
    .clk_sys, .resp_push, .resp_data, .talk_read, .err_read, .clear_cmd,
    .mask_write, .mask_data, .sbyte_query, .serial_poll
  );

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask : settle

  // Wait up to three cycles for answer j
  task automatic get(input int j, output logic [15:0] d);
    logic hit;
    hit = 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 3 && !hit; i++) begin
      @(negedge clk_sys);
      hit = vld[j] === 1'b1;
      d = j == 1 ? err_data : j == 2 ? 16'(sbyte_data) :
          j == 3 ? 16'(poll_data) : 16'(talk_data);
    end
    if (!hit) begin
      err_total++;
      $display("[FAIL] answer %0d expected 1 seen 0", j);
      summarize();
    end
  endtask : get

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    chk("sbyte", 16'h0000, 16'(status_summary_byte));
    chk("mask", 16'h0000, 16'(service_request_mask));
    chk("srq", 16'h0000, 16'(srq_oe));
    chk("resp_ready", 16'h0001, 16'(resp_ready));
    chk("srq_line", 16'h0000, 16'(srq_o));
  endtask : t_reset

  task automatic t_outq();
    logic [15:0] d;
    i_gpib_ctrl_model.issue(QRY, 8'hA5);
    i_gpib_ctrl_model.issue(QRY, 8'h3C);
    settle();
    chk("msg_flag", 16'h0001, 16'(status_summary_byte[BIT_MSG]));
    i_gpib_ctrl_model.issue(TLK, 8'h00);
    get(0, d);
    chk("talk1", 16'h00A5, d);
    i_gpib_ctrl_model.issue(TLK, 8'h00);
    get(0, d);
    chk("talk2", 16'h003C, d);
    settle();
    chk("msg_flag", 16'h0000, 16'(status_summary_byte[BIT_MSG]));
    i_gpib_ctrl_model.query_talk(8'h5A);
    get(0, d);
    chk("talk3", 16'h005A, d);
  endtask : t_outq

  task automatic t_errq();
    logic [15:0] d;
    for (int i = 1; i <= 11; i++) begin
      @(posedge clk_sys);
      err_push <= 1'b1;
      err_code <= 16'(i);
    end
    @(posedge clk_sys);
    err_push <= 1'b0;
    err_code <= 16'hFFFF;
    settle();
    chk("err_full", 16'h0001, 16'(err_full));
    chk("err_flag", 16'h0001, 16'(status_summary_byte[BIT_ERR]));
    for (int i = 1; i <= 10; i++) begin
      i_gpib_ctrl_model.err_fetch();
      get(1, d);
      chk("err_code", 16'(i), d);
    end
    i_gpib_ctrl_model.err_fetch();
    get(1, d);
    chk("err_empty", NO_ERR_CODE, d);
    settle();
    chk("err_flag", 16'h0000, 16'(status_summary_byte[BIT_ERR]));
  endtask : t_errq

  task automatic t_summary();
    int b;
    for (int s = 0; s < 4; s++) begin
      b = s == 0 ? BIT_MEAS : s == 1 ? BIT_QUEST : s == 2 ? BIT_STD : BIT_OPER;
      @(posedge clk_sys);
      ev[s] <= 8'h81;
      en[s] <= 8'h7E;
      settle();
      chk("masked", 16'h0000, 16'(status_summary_byte[b]));
      @(posedge clk_sys);
      en[s] <= 8'h01;
      settle();
      chk("summary", 16'h0001, 16'(status_summary_byte[b]));
      chk("b6_nomask", 16'h0000, 16'(status_summary_byte[BIT_SVC]));
      chk("srq_nomask", 16'h0000, 16'(srq_oe));
      @(posedge clk_sys);
      ev[s] <= 8'h00;
      settle();
      chk("summary", 16'h0000, 16'(status_summary_byte[b]));
    end
  endtask : t_summary

  task automatic t_srq();
    logic [15:0] d;
    logic [7:0]  sb;
    i_gpib_ctrl_model.issue(MSK, 8'hFF);
    settle();
    chk("mask", 16'h00BF, 16'(service_request_mask));
    @(posedge clk_sys);
    ev[0] <= 8'h01;
    settle();
    chk("srq_set", 16'h0001, 16'(srq_oe));
    chk("srq_low", 16'h0000, 16'(srq_o));
    sb = status_summary_byte;
    i_gpib_ctrl_model.issue(SBQ, 8'h00);
    get(2, d);
    chk("stb_b6", 16'h0001, 16'(d[6]));
    settle();
    chk("stb_keep", 16'(sb), 16'(status_summary_byte));
    i_gpib_ctrl_model.issue(PLL, 8'h00);
    get(3, d);
    chk("poll_b6", 16'h0001, 16'(d[6]));
    settle();
    chk("srq_rel", 16'h0000, 16'(srq_oe));
    chk("mss_kept", 16'h0001, 16'(status_summary_byte[BIT_SVC]));
    i_gpib_ctrl_model.issue(PLL, 8'h00);
    get(3, d);
    chk("poll_b6", 16'h0000, 16'(d[6]));
    @(posedge clk_sys);
    en[0] <= 8'h00;
    settle();
    chk("mss_drop", 16'h0000, 16'(status_summary_byte[BIT_SVC]));
    @(posedge clk_sys);
    en[0] <= 8'h01;
    settle();
    chk("srq_again", 16'h0001, 16'(srq_oe));
    i_gpib_ctrl_model.issue(CLR, 8'h00);
    ev[0] <= 8'h00;
    settle();
    chk("cleared", 16'h0000, 16'(status_summary_byte & 8'hEF));
    chk("srq_clr", 16'h0000, 16'(srq_oe));
    i_gpib_ctrl_model.issue(MSK, 8'h00);
    settle();
    chk("mask_zero", 16'h0000, 16'(service_request_mask));
  endtask : t_srq

  task automatic t_freeze();
    @(posedge clk_sys);
    clk_en <= 1'b0;
    ev[0]  <= 8'h01;
    settle();
    chk("frozen", 16'h0000, 16'(status_summary_byte[BIT_MEAS]));
    @(posedge clk_sys);
    clk_en <= 1'b1;
    settle();
    chk("thawed", 16'h0001, 16'(status_summary_byte[BIT_MEAS]));
    @(posedge clk_sys);
    ev[0] <= 8'h00;
    settle();
  endtask : t_freeze

  // ----------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    err_push = 1'b0;
    err_code = 16'h0000;
    foreach (ev[i]) begin
      ev[i] = 8'h00;
      en[i] = 8'h00;
    end
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    t_reset();
    t_outq();
    t_errq();
    t_summary();
    t_srq();
    t_freeze();
    summarize();
  end
endmodule : status_byte_service_request_tb
`default_nettype wire
